// file: design/pio_pkg.sv
// Constants for the two-port parallel I/O block.
// Assumes an 8-bit register port with byte-wide offsets.
package pio_pkg;
    localparam int          ADDR_W            = 3;
    localparam logic [2:0]  OFS_A_LATCH       = 3'h0;
    localparam logic [2:0]  OFS_B_LATCH       = 3'h1;
    localparam logic [2:0]  OFS_A_DIR         = 3'h4;
    localparam logic [2:0]  OFS_B_DIR         = 3'h5;
    localparam logic [2:0]  OFS_KEY_WAKE      = 3'h2;
    localparam int          A_PINS            = 8;
    localparam int          B_PINS            = 4;
    localparam logic [7:0]  DIR_RESET         = 8'h00;
    localparam logic [7:0]  KEY_WAKE_RESET    = 8'h00;
    localparam logic [7:0]  WAKE_CAPABLE_MASK = 8'h7E;
    localparam int          BUS_CLK_EN_BIT    = 7;
endpackage : pio_pkg

// file: design/pio_pin_cell.sv
// One port's pins: output enables and direction-selected read.
// Assumes pin inputs are already synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module pio_pin_cell #(
    parameter int WIDTH = 8
) (
    // Control
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] dir,
    input  wire logic [WIDTH-1:0] force_in,
    // Pin
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] drive_en,
    // Read path
    output logic      [WIDTH-1:0] read_val
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            assign drive_en[i] = dir[i] & ~force_in[i];
            assign read_val[i] = dir[i] ? latch[i] : pin_in[i];
        end
    endgenerate
endmodule : pio_pin_cell
`default_nettype wire

// file: design/dual_parallel_io_ports.sv
// Two parallel ports: port A eight pins, port B four pins, register mapped.
// Assumes a single-cycle strobe register port and synchronous pin inputs.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module dual_parallel_io_ports (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    // Port A pins
    input  wire logic [7:0] port_a_in,
    output logic      [7:0] port_a_out,
    output logic      [7:0] port_a_oe,
    output logic      [7:0] port_a_pullup,
    // Port B pins
    input  wire logic [3:0] port_b_in,
    output logic      [3:0] port_b_out,
    output logic      [3:0] port_b_oe,
    // Bus clock on port B pin 0
    input  wire logic       bus_clk_in,
    output logic            bus_clock_out_enable
);
    logic [7:0] port_a_pin_latch_ff;
    logic [3:0] port_b_pin_latch_ff;
    logic [7:0] port_a_direction_ff;
    logic [3:0] port_b_direction_ff;
    logic       bus_clk_en_ff;
    logic [7:0] key_wake_enable_ff;
    logic [7:0] rdata_ff;
    logic [7:0] a_oe_ff;
    logic [7:0] a_out_ff;
    logic [7:0] a_pu_ff;
    logic [3:0] b_oe_ff;
    logic [3:0] b_out_ff;
    logic       mclk_ff;

    // Next values of the control registers
    wire [7:0]  nxt_port_a_pin_latch;
    wire [3:0]  nxt_port_b_pin_latch;
    wire [7:0]  nxt_port_a_direction;
    wire [3:0]  nxt_port_b_direction;
    wire        nxt_bus_clk_en;
    wire [7:0]  nxt_key_wake_enable;
    wire [7:0]  nxt_rdata;

    // Next values of the pin outputs
    wire [7:0]  nxt_a_oe;
    wire [7:0]  nxt_a_out;
    wire [7:0]  nxt_a_pu;
    wire [3:0]  nxt_b_oe;
    wire [3:0]  nxt_b_out;
    wire        nxt_mclk;

    // Address match against one register offset
    function automatic logic addr_hit(
        input logic [2:0] a,
        input logic [2:0] ofs
    );
        return a == ofs;
    endfunction : addr_hit

    // Register selects, shared by the write and read paths
    wire        hit_a_latch  = addr_hit(addr, pio_pkg::OFS_A_LATCH);
    wire        hit_b_latch  = addr_hit(addr, pio_pkg::OFS_B_LATCH);
    wire        hit_a_dir    = addr_hit(addr, pio_pkg::OFS_A_DIR);
    wire        hit_b_dir    = addr_hit(addr, pio_pkg::OFS_B_DIR);
    wire        hit_wake     = addr_hit(addr, pio_pkg::OFS_KEY_WAKE);

    wire        wr_a_latch   = wr_stb & hit_a_latch;
    wire        wr_b_latch   = wr_stb & hit_b_latch;
    wire        wr_a_dir     = wr_stb & hit_a_dir;
    wire        wr_b_dir     = wr_stb & hit_b_dir;
    wire        wr_wake      = wr_stb & hit_wake;
    wire [7:0]  key_wake_pin = key_wake_enable_ff & pio_pkg::WAKE_CAPABLE_MASK;

    wire [7:0]  a_drive;
    wire [7:0]  a_read;
    wire [3:0]  b_drive;
    wire [3:0]  b_read;

    // Port A: wake enable overrides the direction for driving only
    pio_pin_cell #(
        .WIDTH (pio_pkg::A_PINS)
    ) u_port_a (
        .latch    (port_a_pin_latch_ff),
        .dir      (port_a_direction_ff),
        .force_in (key_wake_pin),
        .pin_in   (port_a_in),
        .drive_en (a_drive),
        .read_val (a_read)
    );

    pio_pin_cell #(
        .WIDTH (pio_pkg::B_PINS)
    ) u_port_b (
        .latch    (port_b_pin_latch_ff),
        .dir      (port_b_direction_ff),
        .force_in (4'h0),
        .pin_in   (port_b_in),
        .drive_en (b_drive),
        .read_val (b_read)
    );

    // Port B pin 0 gives way to the bus clock when enabled
    wire [3:0] b_drive_final;
    wire [3:0] b_out_final;

    genvar b;
    generate
        for (b = 0; b < pio_pkg::B_PINS; b++)
        begin : g_port_b
            if (b == 0)
            begin : g_shared
                assign b_drive_final[b] = b_drive[b] | bus_clk_en_ff;
                assign b_out_final[b]   = bus_clk_en_ff ? bus_clk_in : port_b_pin_latch_ff[b];
            end
            else
            begin : g_plain
                assign b_drive_final[b] = b_drive[b];
                assign b_out_final[b]   = port_b_pin_latch_ff[b];
            end
        end
    endgenerate

    // Read sources, one per mapped offset
    wire [7:0] rd_a_latch = a_read;
    wire [7:0] rd_b_latch = {4'h0, b_read};
    wire [7:0] rd_a_dir   = port_a_direction_ff;
    wire [7:0] rd_b_dir   = {bus_clk_en_ff, 3'h0, port_b_direction_ff};
    wire [7:0] rd_wake    = key_wake_pin;

    wire [7:0] rd_mux =
        hit_a_latch ? rd_a_latch :
        hit_b_latch ? rd_b_latch :
        hit_a_dir   ? rd_a_dir   :
        hit_b_dir   ? rd_b_dir   :
        hit_wake    ? rd_wake    :
                      8'h00;

    // Write selection: a register keeps its value unless its strobe is high
    assign nxt_port_a_pin_latch = wr_a_latch ? wdata      : port_a_pin_latch_ff;
    assign nxt_port_b_pin_latch = wr_b_latch ? wdata[3:0] : port_b_pin_latch_ff;
    assign nxt_port_a_direction = wr_a_dir   ? wdata      : port_a_direction_ff;
    assign nxt_port_b_direction = wr_b_dir   ? wdata[3:0] : port_b_direction_ff;
    assign nxt_bus_clk_en       = wr_b_dir   ? wdata[pio_pkg::BUS_CLK_EN_BIT] : bus_clk_en_ff;
    // Bits outside the wake-capable pins never store a one
    assign nxt_key_wake_enable  = wr_wake    ? (wdata & pio_pkg::WAKE_CAPABLE_MASK)
                                             : key_wake_enable_ff;
    // Read data stands for one cycle only, zero otherwise
    assign nxt_rdata            = rd_stb     ? rd_mux : 8'h00;

    // Pin outputs follow the control registers one cycle later
    assign nxt_a_oe             = a_drive;
    assign nxt_a_out            = port_a_pin_latch_ff;
    assign nxt_a_pu             = key_wake_pin;
    assign nxt_b_oe             = b_drive_final;
    assign nxt_b_out            = b_out_final;
    assign nxt_mclk             = bus_clk_en_ff;

    // Data latches have no reset: contents survive srst
    always_ff @(posedge sys_clk)
    begin
        port_a_pin_latch_ff <= nxt_port_a_pin_latch;
    end

    // Port B latch holds bits 3..0 only
    always_ff @(posedge sys_clk)
    begin
        port_b_pin_latch_ff <= nxt_port_b_pin_latch;
    end

    // Control registers: every pin an input and no wake pin after reset
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            port_a_direction_ff <= pio_pkg::DIR_RESET;
        end
        else
        begin
            port_a_direction_ff <= nxt_port_a_direction;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            port_b_direction_ff <= pio_pkg::DIR_RESET[3:0];
        end
        else
        begin
            port_b_direction_ff <= nxt_port_b_direction;
        end
    end

    // Bus clock enable sits in bit 7 of the port B direction word
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            bus_clk_en_ff <= 1'b0;
        end
        else
        begin
            bus_clk_en_ff <= nxt_bus_clk_en;
        end
    end

    // Wake enables clear on reset
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            key_wake_enable_ff <= pio_pkg::KEY_WAKE_RESET;
        end
        else
        begin
            key_wake_enable_ff <= nxt_key_wake_enable;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Wake enable wins over the direction bit for the drivers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            a_oe_ff <= 8'h00;
        end
        else
        begin
            a_oe_ff <= nxt_a_oe;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            a_out_ff <= 8'h00;
        end
        else
        begin
            a_out_ff <= nxt_a_out;
        end
    end

    // Pull-ups only on the wake-capable pins
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            a_pu_ff <= 8'h00;
        end
        else
        begin
            a_pu_ff <= nxt_a_pu;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            b_oe_ff <= 4'h0;
        end
        else
        begin
            b_oe_ff <= nxt_b_oe;
        end
    end

    // Pin 0 copy of the bus clock lags its source by one cycle
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            b_out_ff <= 4'h0;
        end
        else
        begin
            b_out_ff <= nxt_b_out;
        end
    end

    // Bus clock enable copied out as a flop
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            mclk_ff <= 1'b0;
        end
        else
        begin
            mclk_ff <= nxt_mclk;
        end
    end

    assign rdata                = rdata_ff;
    assign port_a_oe            = a_oe_ff;
    assign port_a_out           = a_out_ff;
    assign port_a_pullup        = a_pu_ff;
    assign port_b_oe            = b_oe_ff;
    assign port_b_out           = b_out_ff;
    assign bus_clock_out_enable = mclk_ff;
endmodule : dual_parallel_io_ports
`default_nettype wire

// file: verif/pio_monitor.sv
// Port checks for the two-port I/O block.
// Bound to the top module; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module pio_monitor (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_a_pullup,
    input wire logic [3:0] port_b_oe,
    input wire logic       bus_clock_out_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic [3:0] w = {4{wr_stb}} & {addr == 3'h0, addr == 3'h4, addr == 3'h5, addr == 3'h2};
    a_out_a: assert property (w[3] ##1 !wr_stb |=> port_a_out == $past(wdata, 2))
        else $error("port A out");
    a_oe_a: assert property (w[2] ##1 !wr_stb |=> port_a_oe == ($past(wdata, 2) & ~port_a_pullup))
        else $error("port A oe");
    pullup_mask_a: assert property (w[0] ##1 !wr_stb |=> port_a_pullup == ($past(wdata, 2) & 8'h7E))
        else $error("pullup");
    b_oe_a: assert property (w[1] ##1 !wr_stb |=> port_b_oe[3:1] == $past(wdata[3:1], 2))
        else $error("port B oe");
    clk_en_a: assert property (w[1] ##1 !wr_stb |=> bus_clock_out_enable == $past(wdata[7], 2))
        else $error("bus clock enable");
    b_pin0_oe_a: assert property (w[1] ##1 !wr_stb |=>
        port_b_oe[0] == ($past(wdata[0], 2) | $past(wdata[7], 2)))
        else $error("port B pin 0 oe");
    oe_pull_a: assert property ((port_a_oe & port_a_pullup) == 8'h00)
        else $error("oe with pullup");
    reset_state_a: assert property ($fell(srst) |-> {port_a_oe, port_a_pullup, port_b_oe} == 20'h0)
        else $error("reset state");
    rd_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
        else $error("rdata idle");
    cover property (w[2]);
    cover property (w[0]);
    cover property (rd_stb && addr == 3'h0);
endmodule : pio_monitor
bind dual_parallel_io_ports pio_monitor monitor (.sys_clk, .srst, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .port_a_out, .port_a_oe, .port_a_pullup, .port_b_oe, .bus_clock_out_enable);
`default_nettype wire

// file: verif/pio_board.sv
// Board model: resolves pins from drive, pull-up and external level.
// Undriven, unpulled pins take the level set on ext_a and ext_b.
`timescale 1ns/100ps
`default_nettype none
module pio_board (
    // Device side
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe,
    input  wire logic [7:0] a_pull,
    input  wire logic [3:0] b_out,
    input  wire logic [3:0] b_oe,
    // Board side
    input  wire logic [7:0] ext_a,
    input  wire logic [3:0] ext_b,
    output logic      [7:0] a_pin,
    output logic      [3:0] b_pin
);
    assign a_pin = (a_oe & a_out) | (~a_oe & (a_pull | ext_a));
    assign b_pin = (b_oe & b_out) | (~b_oe & ext_b);
endmodule : pio_board
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the two-port I/O block.
// Register port driven by tasks; pins resolved by the board model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       sys_clk = 1'b0;
    logic       srst    = 1'b1;
    logic [2:0] addr    = 3'h0;
    logic [7:0] wdata   = 8'h00;
    logic       wr_stb  = 1'b0;
    logic       rd_stb  = 1'b0;
    logic [7:0] rdata, a_out, a_oe, a_pull, a_pin;
    logic [3:0] b_out, b_oe, b_pin;
    logic       clk_en;
    logic       bus_clk_src = 1'b0;
    int         mismatches      = 0;
    int         samples_checked = 0;
    dual_parallel_io_ports dut (.sys_clk, .srst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .port_a_in(a_pin), .port_a_out(a_out), .port_a_oe(a_oe), .port_a_pullup(a_pull),
        .port_b_in(b_pin), .port_b_out(b_out), .port_b_oe(b_oe), .bus_clk_in(bus_clk_src),
        .bus_clock_out_enable(clk_en));
    pio_board board (.a_out, .a_oe, .a_pull, .b_out, .b_oe, .ext_a(8'h3C), .ext_b(4'h9),
        .a_pin, .b_pin);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        chk(rdata, exp);
    endtask : rd
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rd(3'h4, 8'h00);
        rd(3'h5, 8'h00);
        rd(3'h2, 8'h00);
        wr(3'h0, 8'hA5);
        rd(3'h0, 8'h3C);
        wr(3'h4, 8'hF0);
        rd(3'h0, 8'hAC);
        chk(a_pin, 8'hAC);
        chk(a_out, 8'hA5);
        wr(3'h2, 8'hFF);
        rd(3'h2, 8'h7E);
        chk(a_oe, 8'h80);
        rd(3'h0, 8'hAE);
        wr(3'h4, 8'h00);
        rd(3'h0, 8'h7E);
        wr(3'h1, 8'hFF);
        wr(3'h5, 8'hFF);
        rd(3'h5, 8'h8F);
        rd(3'h1, 8'h0F);
        chk({3'h0, clk_en, b_oe}, 8'h1F);
        chk({4'h0, b_out}, 8'h0E);
        @(posedge sys_clk);
        bus_clk_src <= 1'b1;
        rd(3'h5, 8'h8F);
        chk({4'h0, b_out}, 8'h0F);
        wr(3'h5, 8'h00);
        bus_clk_src <= 1'b0;
        rd(3'h1, 8'h09);
        chk({4'h0, b_out}, 8'h0F);
        rd(3'h3, 8'h00);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        wr(3'h4, 8'hFF);
        rd(3'h0, 8'hA5);
        chk(a_pull, 8'h00);
        test_done;
    end
endmodule : testbench
`default_nettype wire
